// [hw/scd_params.svh]
/*
 * Offsets, field positions, reset values and code constants of the SENT
 * configuration decode block.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SCD_ADDR_W 4
`define SCD_OFF_CLASS 4'h0
`define SCD_OFF_FORMAT 4'h1
`define SCD_OFF_THRESH 4'h2
`define SCD_OFF_TYPECODE 4'h3
`define SCD_OFF_STATUS 4'h4
`define SCD_OFF_IDENT 4'h5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SCD_RST_CLASS 4'h0
`define SCD_RST_FORMAT 3'h4
`define SCD_RST_TEMP 5'h1f
`define SCD_RST_THRESH_LO 7'h00
`define SCD_IDENT_VAL 16'h5a5a

// ----------------------------------------------------------------------
// Threshold register fields
// ----------------------------------------------------------------------
`define SCD_TEMP_MSB 11
`define SCD_TEMP_LSB 7
`define SCD_TEMP_EN_BIT 6
`define SCD_CRC_EN_BIT 5
`define SCD_SUP_EN_BIT 4
`define SCD_MASK1_BIT 2
`define SCD_MASK0_BIT 3
`define SCD_SLOPE_MSB 1
`define SCD_SLOPE_LSB 0

// ----------------------------------------------------------------------
// Temperature scale
// ----------------------------------------------------------------------
`define SCD_TEMP_OFFSET_C 45
`define SCD_TEMP_STEP_C 8

// ----------------------------------------------------------------------
// Sensor-type codes
// ----------------------------------------------------------------------
`define SCD_TYPE_PEDAL_DUAL 12'h051
`define SCD_TYPE_PEDAL1_SEC 12'h052
`define SCD_TYPE_PEDAL2_SEC 12'h053
`define SCD_TYPE_THR_DUAL 12'h054
`define SCD_TYPE_THR1_SEC 12'h055
`define SCD_TYPE_THR2_SEC 12'h056
`define SCD_TYPE_ANGLE 12'h059
`define SCD_TYPE_ANGLE_SEC 12'h05a
`define SCD_TYPE_ANGLE_HS 12'h062
`define SCD_TYPE_ANGLE_DUAL 12'h063
`define SCD_TYPE_ANGLE_H4 12'h064
`define SCD_TYPE_ANGLE_RSV 12'h066
`define SCD_TYPE_NONE 12'h000

`endif

// [hw/scd_pkg.sv]
/*
 * Types of the SENT configuration decode block.
 * Assumes scd_params.svh is on the include path.
 */
package scd_pkg;
	`include "scd_params.svh"

	typedef enum logic [2:0] {
		SCD_FMT_A1 = 3'b000,
		SCD_FMT_A3 = 3'b001,
		SCD_FMT_H1 = 3'b010,
		SCD_FMT_H3 = 3'b011,
		SCD_FMT_H4 = 3'b100
	} scd_format_t;

	typedef enum logic [3:0] {
		SCD_CLS_PEDAL_DUAL = 4'b0000,
		SCD_CLS_PEDAL1_SEC = 4'b0001,
		SCD_CLS_PEDAL2_SEC = 4'b0010,
		SCD_CLS_THR_DUAL = 4'b0011,
		SCD_CLS_THR1_SEC = 4'b0100,
		SCD_CLS_THR2_SEC = 4'b0101,
		SCD_CLS_ANGLE = 4'b0110,
		SCD_CLS_ANGLE_SEC = 4'b0111,
		SCD_CLS_ANGLE_HS = 4'b1000,
		SCD_CLS_ANGLE_DUAL = 4'b1001,
		SCD_CLS_ANGLE_H4 = 4'b1010,
		SCD_CLS_ANGLE_RSV = 4'b1011
	} scd_class_t;
endpackage : scd_pkg

// [hw/scd_config_decode.sv]
/*
 * SENT configuration decode: sensor class to sensor-type code, frame
 * format select, temperature threshold and diagnostic settings.
 * Assumes a register master on clk with one-cycle strobes, and status
 * inputs from logic on the same clock.
 */
`timescale 1ns/10ps
// Function
// - Class 0000b, the default, reports type code 051h.
// - Classes 0001b and 0010b report 052h and 053h.
// - Classes 0011b, 0100b and 0101b report 054h, 055h and 056h.
// - Class 0110b reports 059h and class 0111b reports 05Ah.
// - Classes 1000b, 1001b and 1010b report 062h, 063h and 064h.
// - Class 1011b reports 066h and classes 1100b to 1111b report zero.
// - Format 000b selects A.1 and 001b selects A.3.
// - Format 010b selects H.1, 011b H.3 and 100b, the default, H.4.
// - H.1 uses A.1 data mapping but keeps diagnostic codes out of the data range.
// - H.4 uses A.3 data mapping but keeps diagnostic codes out of the data range.
// - Bits 11..7 hold the warning level (threshold + 45 C) / 8 C, default 1Fh.
// - Bits 6, 5 and 4 enable the temperature, bit-error/CRC2 and supply warnings.
// - Bit 3 masks status-nibble bit 0, bit 2 masks bit 1; bits 1..0 select slope time.
module scd_config_decode
	import scd_pkg::*;
#(
	parameter int DATA_W = 12
) (
	input wire logic clk, // 100 MHz system clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic [`SCD_ADDR_W-1:0] regAddr, // Register word address
	input wire logic [15:0] regWdata, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	input wire logic [DATA_W-1:0] rawData, // Fast-channel sample
	input wire logic [4:0] tempLevel, // Measured temperature code
	input wire logic crcErr, // Single-bit or CRC2 error seen
	input wire logic supplyErr, // Supply monitor fault
	output logic [15:0] regRdata, // Read data, cycle after strobe
	output logic [11:0] sensorType, // Slow-channel sensor-type code
	output scd_format_t frameFormat, // Selected protocol format
	output logic [DATA_W-1:0] fastData, // Fast-channel data, clipped in H.1 and H.4
	output logic [1:0] statusNibble, // Status nibble bits 1..0
	output logic [2:0] warnFlags, // Temperature, CRC, supply warnings
	output logic [1:0] slopeSel // Output slope time select
);
	`include "scd_params.svh"

	localparam logic [DATA_W-1:0] DATA_MAX = {DATA_W{1'b1}};
	localparam logic [DATA_W-1:0] DIAG_LO = DATA_W'(1);
	localparam logic [DATA_W-1:0] DIAG_HI = DATA_MAX - DATA_W'(8);

	logic [3:0] class_r;
	logic [2:0] format_r;
	logic [15:0] thresh_r;
	logic [11:0] typeNxt;
	logic [DATA_W-1:0] dataNxt;
	logic [2:0] warnNxt;

	// ------------------------------------------------------------------
	// Sensor-type decode
	// ------------------------------------------------------------------
	function automatic logic [11:0] typeCode(input logic [3:0] cls);
		case (cls)
			SCD_CLS_PEDAL_DUAL: typeCode = `SCD_TYPE_PEDAL_DUAL;
			SCD_CLS_PEDAL1_SEC: typeCode = `SCD_TYPE_PEDAL1_SEC;
			SCD_CLS_PEDAL2_SEC: typeCode = `SCD_TYPE_PEDAL2_SEC;
			SCD_CLS_THR_DUAL: typeCode = `SCD_TYPE_THR_DUAL;
			SCD_CLS_THR1_SEC: typeCode = `SCD_TYPE_THR1_SEC;
			SCD_CLS_THR2_SEC: typeCode = `SCD_TYPE_THR2_SEC;
			SCD_CLS_ANGLE: typeCode = `SCD_TYPE_ANGLE;
			SCD_CLS_ANGLE_SEC: typeCode = `SCD_TYPE_ANGLE_SEC;
			SCD_CLS_ANGLE_HS: typeCode = `SCD_TYPE_ANGLE_HS;
			SCD_CLS_ANGLE_DUAL: typeCode = `SCD_TYPE_ANGLE_DUAL;
			SCD_CLS_ANGLE_H4: typeCode = `SCD_TYPE_ANGLE_H4;
			SCD_CLS_ANGLE_RSV: typeCode = `SCD_TYPE_ANGLE_RSV;
			default: typeCode = `SCD_TYPE_NONE;
		endcase
	endfunction : typeCode

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			class_r <= `SCD_RST_CLASS;
		end else if (regWr && regAddr == `SCD_OFF_CLASS) begin
			class_r <= regWdata[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			format_r <= `SCD_RST_FORMAT;
		end else if (regWr && regAddr == `SCD_OFF_FORMAT) begin
			// Unlisted codes are refused; the old format stays
			if (regWdata[2:0] <= SCD_FMT_H4) begin
				format_r <= regWdata[2:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			thresh_r <= {4'h0, `SCD_RST_TEMP, `SCD_RST_THRESH_LO};
		end else if (regWr && regAddr == `SCD_OFF_THRESH) begin
			thresh_r <= regWdata;
		end
	end

	// ------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			regRdata <= 16'h0000;
		end else if (regRd) begin
			case (regAddr)
				`SCD_OFF_CLASS: regRdata <= {12'h000, class_r};
				`SCD_OFF_FORMAT: regRdata <= {13'h0000, format_r};
				`SCD_OFF_THRESH: regRdata <= thresh_r;
				`SCD_OFF_TYPECODE: regRdata <= {4'h0, sensorType};
				`SCD_OFF_STATUS: regRdata <= {11'h000, warnFlags, statusNibble};
				`SCD_OFF_IDENT: regRdata <= `SCD_IDENT_VAL; // Value is arbitrary
				default: regRdata <= 16'h0000;
			endcase
		end else begin
			regRdata <= 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// Decoded outputs
	// ------------------------------------------------------------------
	always_comb begin
		typeNxt = typeCode(class_r);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sensorType <= `SCD_TYPE_PEDAL_DUAL;
			frameFormat <= SCD_FMT_H4;
			slopeSel <= 2'h0;
		end else begin
			sensorType <= typeNxt;
			frameFormat <= scd_format_t'(format_r);
			slopeSel <= thresh_r[`SCD_SLOPE_MSB:`SCD_SLOPE_LSB];
		end
	end

	// ------------------------------------------------------------------
	// Fast-channel data range
	// ------------------------------------------------------------------
	// H.1 and H.4 keep the diagnostic codes at both ends free of data; H.3 passes raw data
	always_comb begin
		dataNxt = rawData;
		case (format_r)
			SCD_FMT_H1, SCD_FMT_H4: begin
				if (rawData < DIAG_LO) begin
					dataNxt = DIAG_LO;
				end else if (rawData > DIAG_HI) begin
					dataNxt = DIAG_HI;
				end
			end
			default: dataNxt = rawData;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fastData <= '0;
		end else begin
			fastData <= dataNxt;
		end
	end

	// ------------------------------------------------------------------
	// Warnings and status nibble
	// ------------------------------------------------------------------
	always_comb begin
		warnNxt[2] = thresh_r[`SCD_TEMP_EN_BIT]
			&& (tempLevel >= thresh_r[`SCD_TEMP_MSB:`SCD_TEMP_LSB]);
		warnNxt[1] = thresh_r[`SCD_CRC_EN_BIT] && crcErr;
		warnNxt[0] = thresh_r[`SCD_SUP_EN_BIT] && supplyErr;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			warnFlags <= 3'h0;
			statusNibble <= 2'h0;
		end else begin
			warnFlags <= warnNxt;
			statusNibble[0] <= (|warnNxt) && !thresh_r[`SCD_MASK0_BIT];
			statusNibble[1] <= (|warnNxt) && !thresh_r[`SCD_MASK1_BIT];
		end
	end
endmodule : scd_config_decode

// [tb/scd_decode_monitor.sv]
/* Port checker of the config decode block.
 * Assumes one clock and registered outputs. */
`timescale 1ns/10ps
module scd_decode_monitor
	import scd_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic [3:0] regAddr, // Address
	input wire logic [15:0] regWdata, // Wdata
	input wire logic regWr, // Write
	input wire logic regRd, // Read
	input wire logic crcErr, // Error
	input wire logic [15:0] regRdata, // Rdata
	input wire logic [11:0] sensorType, // Type
	input wire scd_format_t frameFormat, // Format
	input wire logic [2:0] warnFlags, // Warnings
	input wire logic [1:0] statusNibble, // Status
	input wire logic [1:0] slopeSel // Slope
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence wrCls(logic [3:0] v);
		regWr && regAddr == 4'h0 && regWdata[3:0] == v;
	endsequence
	sequence wrThr;
		regWr && regAddr == 4'h2;
	endsequence
	chk_type_default: assert property (wrCls(4'h0) |-> ##2 sensorType == 12'h051)
		else $error("class 0 code wrong");
	chk_type_hfmt: assert property (wrCls(4'h9) |-> ##2 sensorType == 12'h063)
		else $error("class 9 code wrong");
	chk_type_rsv: assert property (wrCls(4'hc) |-> ##2 sensorType == 12'h000)
		else $error("class 12 code wrong");
	chk_fmt_sel: assert property (regWr && regAddr == 4'h1 && regWdata[2:0] <= 3'h4
		|-> ##2 frameFormat == $past(regWdata[2:0], 2)) else $error("format wrong");
	chk_warn_cause: assert property (warnFlags[1] |-> $past(crcErr))
		else $error("crc warning without cause");
	chk_nibble_src: assert property (|statusNibble |-> |warnFlags)
		else $error("status bit without warning");
	chk_slope_sel: assert property (wrThr ##1 (!regWr) [*2] |=>
		slopeSel == $past(regWdata[1:0], 3)) else $error("slope wrong");
	chk_thr_back: assert property (wrThr ##2 (regRd && regAddr == 4'h2) |=>
		regRdata == $past(regWdata, 3)) else $error("threshold readback wrong");
	chk_read_idle: assert property (!regRd |=> regRdata == 16'h0000)
		else $error("read data outside its cycle");
endmodule : scd_decode_monitor
bind scd_config_decode scd_decode_monitor u_scd_decode_monitor (.clk(clk), .reset_n(reset_n),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .crcErr(crcErr),
	.regRdata(regRdata), .sensorType(sensorType), .frameFormat(frameFormat),
	.warnFlags(warnFlags), .statusNibble(statusNibble), .slopeSel(slopeSel));

// [tb/scd_rx_model.sv]
/* Receiver-side model: latches status and data of each frame.
 * Assumes the decode outputs on the same clock. */
`timescale 1ns/10ps
module scd_rx_model (
	input wire logic clk, // Clock
	input wire logic [11:0] fastData, // Data
	input wire logic [1:0] statusNibble, // Status
	output logic [13:0] rxFrame // Frame
);
	always_ff @(posedge clk) begin
		rxFrame <= {statusNibble, fastData};
	end
endmodule : scd_rx_model

// [tb/test_scd_config_decode.sv]
/* Testbench of the config decode block and receiver model.
 * Assumes scd_pkg and the design compiled first. */
`timescale 1ns/10ps
module test_scd_config_decode
	import scd_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [11:0] rawData = 12'h000;
	logic [4:0] tempLevel = 5'h00;
	logic crcErr = 1'b0;
	logic supplyErr = 1'b0;
	logic [15:0] regRdata, rdVal;
	logic [11:0] sensorType, fastData;
	scd_format_t frameFormat;
	logic [1:0] statusNibble, slopeSel;
	logic [2:0] warnFlags;
	logic [13:0] rxFrame;
	int failures = 0;
	int totalChecks = 0;
	logic [11:0] typ [16] = '{12'h051, 12'h052, 12'h053, 12'h054, 12'h055, 12'h056, 12'h059,
		12'h05a, 12'h062, 12'h063, 12'h064, 12'h066, 12'h000, 12'h000, 12'h000, 12'h000};
	scd_config_decode u_scd_config_decode (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .rawData(rawData),
		.tempLevel(tempLevel), .crcErr(crcErr), .supplyErr(supplyErr), .regRdata(regRdata),
		.sensorType(sensorType), .frameFormat(frameFormat), .fastData(fastData),
		.statusNibble(statusNibble), .warnFlags(warnFlags), .slopeSel(slopeSel));
	scd_rx_model u_scd_rx_model (.clk(clk), .fastData(fastData), .statusNibble(statusNibble),
		.rxFrame(rxFrame));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 rdVal = regRdata;
	endtask : rd
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask : settle
	task automatic give_verdict();
		if (failures == 0 && totalChecks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task automatic t_class();
		for (int i = 0; i < 16; i++) begin
			wr(4'h0, 16'(i));
			settle();
			check(16'(sensorType), 16'(typ[i]));
			rd(4'h3);
			check(rdVal, 16'(typ[i]));
		end
	endtask : t_class
	task automatic t_format();
		for (int i = 0; i < 8; i++) begin
			wr(4'h1, 16'(i));
			settle();
			check(16'(frameFormat), (i < 5) ? 16'(i) : 16'h0004);
		end
	endtask : t_format
	task automatic clip(input logic [2:0] f, input logic [11:0] r, input logic [11:0] e);
		wr(4'h1, 16'(f));
		rawData <= r;
		settle();
		check(16'(rxFrame[11:0]), 16'(e));
	endtask : clip
	task automatic t_warn();
		wr(4'h2, 16'h07f2);
		rd(4'h2);
		check(rdVal, 16'h07f2);
		tempLevel <= 5'h0f;
		crcErr <= 1'b1;
		settle();
		check(16'({warnFlags, statusNibble, slopeSel}), 16'h006e);
		wr(4'h2, 16'h07fa);
		tempLevel <= 5'h0e;
		crcErr <= 1'b0;
		supplyErr <= 1'b1;
		settle();
		check(16'({warnFlags, statusNibble, slopeSel}), 16'h001a);
		rd(4'h4);
		check(rdVal, 16'h0006);
		wr(4'h2, 16'h0780);
		settle();
		check(16'(warnFlags), 16'h0000);
	endtask : t_warn
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		settle();
		check(16'(sensorType), 16'h0051);
		check(16'(frameFormat), 16'h0004);
		rd(4'h2);
		check(rdVal, 16'h0f80);
		t_class();
		t_format();
		clip(3'h0, 12'h000, 12'h000);
		clip(3'h2, 12'h000, 12'h001);
		clip(3'h2, 12'h123, 12'h123);
		clip(3'h4, 12'hfff, 12'hff7);
		t_warn();
		give_verdict();
	end
	initial begin
		#200000;
		failures++;
		give_verdict();
	end
endmodule : test_scd_config_decode
